// ### inc/cfg_port_pkg.sv
package cfg_port_pkg;
  // Instruction and data widths of a serial frame.
  localparam int INSTR_BITS = 16;
  localparam int WORD_BITS  = 8;
  localparam int ADDR_BITS  = 13;
  // Register offsets inside the device.
  localparam logic [12:0] PORT_CFG_ADDR  = 13'h0000;
  localparam logic [12:0] CHIP_ID_ADDR   = 13'h0001;
  localparam logic [12:0] TEST_CTRL_ADDR = 13'h000d;
  // Port configuration fields; nibbles are mirrored.
  localparam int CFG_LSB_FIRST_HI = 6;
  localparam int CFG_SOFT_RST_HI  = 5;
  localparam int CFG_SOFT_RST_LO  = 2;
  localparam int CFG_LSB_FIRST_LO = 1;
  localparam logic [7:0] PORT_CFG_RESET  = 8'h18;
  localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
  // Test control fields.
  localparam int TEST_PN_LONG_RST  = 4;
  localparam int TEST_PN_SHORT_RST = 5;
  localparam logic [3:0] TEST_OFF      = 4'h0;
  localparam logic [3:0] TEST_ONE_HIGH = 4'hb;
  localparam logic [15:0] ONE_HIGH_WORD = 16'h8000;
  localparam logic [8:0]  PN9_SEED      = 9'h1ff;
  localparam logic [22:0] PN23_SEED     = 23'h7fffff;
  // Chip identity; this value is arbitrary.
  localparam logic [7:0] CHIP_ID_VALUE = 8'h5a;
  // Controller register map (AXI4-Lite byte offsets).
  localparam logic [3:0] CTL_ADDR_OFS  = 4'h0;
  localparam logic [3:0] CTL_DATA_OFS  = 4'h4;
  localparam logic [3:0] CTL_CMD_OFS   = 4'h8;
  localparam logic [3:0] CTL_STAT_OFS  = 4'hc;
  // Controller shift clock divider: half period in aclk cycles.
  localparam int SCLK_HALF = 4;
endpackage : cfg_port_pkg

// ### inc/cfg_port_if.sv
`timescale 1ns/1ps
interface cfg_port_if;
  logic sclk;        // Shift clock from controller.
  logic cs1_n;       // Bank one select, active low.
  logic cs2_n;       // Bank two select, active low.
  logic sdio_ctl_o;  // Controller data out.
  logic sdio_ctl_oe_n; // Controller drives when low.
  logic sdio_dev_o;  // Device data out.
  logic sdio_dev_oe_n; // Device drives when low.
  logic sdio;        // Resolved line level.
  // Resolve the shared line; pulled low when nobody drives.
  assign sdio = !sdio_dev_oe_n ? sdio_dev_o :
                !sdio_ctl_oe_n ? sdio_ctl_o : 1'b0;
  modport device (input sclk, cs1_n, cs2_n, sdio,
                  output sdio_dev_o, sdio_dev_oe_n);
  modport ctrl (output sclk, cs1_n, cs2_n, sdio_ctl_o, sdio_ctl_oe_n,
                input sdio);
endinterface : cfg_port_if

// ### core/cfg_port_device.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cfg_port_device (
  input  wire logic        aclk,          // Sample-side clock.
  input  wire logic        aresetn,       // Synchronous reset, low.
  cfg_port_if.device       port,          // Serial link.
  input  wire logic        sample_clk_ok, // Sample clock present.
  input  wire logic        power_down_pin,// Dedicated power-down pin.
  input  wire logic [13:0] adc_sample,    // Converted sample.
  output logic [15:0]      out_word,      // Word to output formatter.
  output logic             two_lane,      // Two-lane output mode.
  output logic             powered_down,  // Power-down in effect.
  output logic [1:0]       bank_access    // Bank one/two port access.
);
  // Two-flop synchronisers for all link inputs.
  logic [1:0] s_sclk, s_cs1, s_cs2, s_sdio;
  logic sclk_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_sclk <= 2'h0; s_cs1 <= 2'h3; s_cs2 <= 2'h3; s_sdio <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      s_sclk <= {s_sclk[0], port.sclk};
      s_cs1  <= {s_cs1[0], port.cs1_n};
      s_cs2  <= {s_cs2[0], port.cs2_n};
      s_sdio <= {s_sdio[0], port.sdio};
      sclk_d <= s_sclk[1];
    end
  end
  logic sel, rise, fall;
  assign sel  = !s_cs1[1] || !s_cs2[1];
  assign rise = sel && s_sclk[1] && !sclk_d;
  assign fall = sel && !s_sclk[1] && sclk_d;
  assign bank_access = {!s_cs2[1], !s_cs1[1]};

  // Straps are captured once, while both selects are high, and only after
  // the synchronisers hold real pin levels rather than their reset values.
  logic strap_done, strap_lane, strap_pat;
  logic [1:0] strap_fill;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_fill <= 2'h0;
      strap_done <= 1'b0; strap_lane <= 1'b1; strap_pat <= 1'b0;
    end else begin
      strap_fill <= {strap_fill[0], 1'b1};
      if (strap_fill[1] && !strap_done) begin
        strap_done <= 1'b1;
        if (s_cs1[1] && s_cs2[1]) begin
          strap_lane <= s_sdio[1];
          strap_pat  <= s_sclk[1];
        end
      end
    end
  end
  assign two_lane = strap_lane;
  assign powered_down = power_down_pin;

  // Frame state: bit counters, instruction and shift register.
  logic [3:0]  bitcnt;
  logic        in_instr, is_read, stream;
  logic [1:0]  bytes_left;
  logic [15:0] instr;
  logic [7:0]  shreg, rdata;
  logic [12:0] addr;
  logic [7:0]  port_cfg, test_ctrl;
  logic        lsb_first;
  assign lsb_first = port_cfg[cfg_port_pkg::CFG_LSB_FIRST_LO];

  function automatic logic [7:0] reg_read(input logic [12:0] a,
                                          input logic [7:0] c,
                                          input logic [7:0] t);
    if (a == cfg_port_pkg::PORT_CFG_ADDR) reg_read = c;
    else if (a == cfg_port_pkg::CHIP_ID_ADDR)
      reg_read = cfg_port_pkg::CHIP_ID_VALUE;
    else if (a == cfg_port_pkg::TEST_CTRL_ADDR) reg_read = t;
    else reg_read = 8'h00;
  endfunction : reg_read

  // Serial engine; select high between bytes keeps state, so a stalled
  // frame resumes at the next byte.
  logic wr_stb;
  logic [7:0] wr_byte;
  logic [15:0] next_instr;
  logic [7:0]  next_byte;
  assign next_instr = {instr[14:0], s_sdio[1]};
  assign next_byte = lsb_first ? {s_sdio[1], shreg[7:1]}
                               : {shreg[6:0], s_sdio[1]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitcnt <= 4'h0; in_instr <= 1'b1; is_read <= 1'b0;
      stream <= 1'b0; bytes_left <= 2'h0; instr <= 16'h0000;
      shreg <= 8'h00; addr <= 13'h0000; wr_stb <= 1'b0;
      wr_byte <= 8'h00; rdata <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (rise && in_instr) begin
        instr  <= next_instr;
        bitcnt <= bitcnt + 4'h1;
        if (bitcnt == 4'hf) begin
          in_instr   <= 1'b0;
          bitcnt     <= 4'h0;
          is_read    <= next_instr[15];
          stream     <= next_instr[14:13] == 2'h3;
          bytes_left <= next_instr[14:13];
          addr       <= next_instr[12:0];
          rdata      <= reg_read(next_instr[12:0], port_cfg, test_ctrl);
        end
      end else if (rise) begin
        shreg  <= next_byte;
        bitcnt <= bitcnt + 4'h1;
        if (bitcnt == 4'h7) begin
          bitcnt <= 4'h0;
          if (!is_read) begin
            wr_stb  <= 1'b1;
            wr_byte <= next_byte;
          end
          // Address walks down for MSB first, up for LSB first.
          addr <= lsb_first ? addr + 13'h1 : addr - 13'h1;
          rdata <= reg_read(lsb_first ? addr + 13'h1 : addr - 13'h1,
                            port_cfg, test_ctrl);
          if (!stream && bytes_left == 2'h0)
            in_instr <= 1'b1;
          else if (!stream)
            bytes_left <= bytes_left - 2'h1;
        end
      end
    end
  end

  // Read data launch on falling edges; line turns at the fall after the
  // last address bit, within half a shift clock.
  logic [2:0] out_idx;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port.sdio_dev_oe_n <= 1'b1;
      port.sdio_dev_o    <= 1'b0;
    end else if (!sel) begin
      port.sdio_dev_oe_n <= 1'b1;
    end else if (fall && !in_instr && is_read) begin
      port.sdio_dev_oe_n <= 1'b0;
      port.sdio_dev_o    <= rdata[out_idx];
    end else if (fall && in_instr) begin
      port.sdio_dev_oe_n <= 1'b1;
    end
  end
  assign out_idx = lsb_first ? bitcnt[2:0] : 3'h7 - bitcnt[2:0];

  // Written address is one step past the byte just taken.
  function automatic logic addr_hit(input logic [12:0] a);
    addr_hit = (lsb_first ? addr - 13'h1 : addr + 13'h1) == a;
  endfunction : addr_hit

  // Register writes; soft reset restores defaults and clears itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_cfg  <= cfg_port_pkg::PORT_CFG_RESET;
      test_ctrl <= cfg_port_pkg::TEST_CTRL_RESET;
    end else if (wr_stb && addr_hit(cfg_port_pkg::PORT_CFG_ADDR)) begin
      if (wr_byte[cfg_port_pkg::CFG_SOFT_RST_HI] ||
          wr_byte[cfg_port_pkg::CFG_SOFT_RST_LO]) begin
        port_cfg  <= cfg_port_pkg::PORT_CFG_RESET;
        test_ctrl <= cfg_port_pkg::TEST_CTRL_RESET;
      end else begin
        port_cfg <= {1'b0, wr_byte[cfg_port_pkg::CFG_LSB_FIRST_HI], 4'h6,
                     wr_byte[cfg_port_pkg::CFG_LSB_FIRST_HI], 1'b0};
      end
    end else if (wr_stb && addr_hit(cfg_port_pkg::TEST_CTRL_ADDR)) begin
      test_ctrl <= wr_byte;
    end
  end

  // Pseudorandom generators, restarted by their reset bits.
  logic [8:0]  pn9;
  logic [22:0] pn23;
  always_ff @(posedge aclk) begin
    if (!aresetn || test_ctrl[cfg_port_pkg::TEST_PN_SHORT_RST])
      pn9 <= cfg_port_pkg::PN9_SEED;
    else if (sample_clk_ok)
      pn9 <= {pn9[7:0], pn9[8] ^ pn9[4]};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || test_ctrl[cfg_port_pkg::TEST_PN_LONG_RST])
      pn23 <= cfg_port_pkg::PN23_SEED;
    else if (sample_clk_ok)
      pn23 <= {pn23[21:0], pn23[22] ^ pn23[17]};
  end

  // Output word: one-high, PN9 or PN23 replaces samples in modes b, 6 and 5; other test modes output zero.
  logic [3:0] mode;
  assign mode = test_ctrl[3:0];
  always_ff @(posedge aclk) begin
    if (!aresetn)
      out_word <= 16'h0000;
    else if (!sample_clk_ok)
      out_word <= out_word;
    else if (strap_pat && mode == cfg_port_pkg::TEST_OFF)
      out_word <= cfg_port_pkg::ONE_HIGH_WORD;
    else if (mode == cfg_port_pkg::TEST_OFF)
      out_word <= {adc_sample, 2'h0};
    else if (mode == cfg_port_pkg::TEST_ONE_HIGH)
      out_word <= cfg_port_pkg::ONE_HIGH_WORD;
    else if (mode == 4'h6)
      out_word <= {pn9, 7'h00};
    else if (mode == 4'h5)
      out_word <= pn23[22:7];
    else
      out_word <= 16'h0000;
  end
endmodule : cfg_port_device

// ### core/cfg_port_ctrl.sv
`timescale 1ns/1ps
// Controller end: an AXI4-Lite slave whose command register runs one
// serial frame on the link. Both selects are driven low and high together and the port
// is left idle between commands.
module cfg_port_ctrl (
  input  wire logic        aclk,     // System clock.
  input  wire logic        aresetn,  // Synchronous reset, low.
  cfg_port_if.ctrl         port,     // Serial link.
  input  wire logic [3:0]  awaddr,   // Write address.
  input  wire logic        awvalid,  // Write address valid.
  output logic             awready,  // Write address ready.
  input  wire logic [31:0] wdata,    // Write data.
  input  wire logic [3:0]  wstrb,    // Byte strobes.
  input  wire logic        wvalid,   // Write data valid.
  output logic             wready,   // Write data ready.
  output logic [1:0]       bresp,    // Write response.
  output logic             bvalid,   // Write response valid.
  input  wire logic        bready,   // Write response ready.
  input  wire logic [3:0]  araddr,   // Read address.
  input  wire logic        arvalid,  // Read address valid.
  output logic             arready,  // Read address ready.
  output logic [31:0]      rdata,    // Read data.
  output logic [1:0]       rresp,    // Read response.
  output logic             rvalid,   // Read data valid.
  input  wire logic        rready,   // Read data ready.
  output logic             power_down_pin // Held low for register control.
);
  logic [15:0] instr;
  logic [7:0]  wbyte, rbyte;
  logic        busy, start;
  logic [1:0]  sel_lsb;
  logic [3:0]  aw_q;
  logic        aw_have, w_have;
  logic [31:0] w_q;
  assign power_down_pin = 1'b0;

  // Write channel: address and data are taken in either order.
  assign awready = !aw_have && !bvalid;
  assign wready  = !w_have && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0; w_have <= 1'b0; aw_q <= 4'h0; w_q <= 32'h0;
      bvalid <= 1'b0;
    end else begin
      if (awvalid && awready) begin aw_have <= 1'b1; aw_q <= awaddr; end
      if (wvalid && wready) begin w_have <= 1'b1; w_q <= wdata; end
      if (aw_have && w_have) begin
        aw_have <= 1'b0; w_have <= 1'b0; bvalid <= 1'b1;
      end
      if (bvalid && bready) bvalid <= 1'b0;
    end
  end
  assign bresp = 2'h0;
  assign start = aw_have && w_have && !busy &&
                 aw_q == cfg_port_pkg::CTL_CMD_OFS && w_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= 16'h0000; wbyte <= 8'h00; sel_lsb <= 2'h0;
    end else if (aw_have && w_have && wstrb != 4'h0) begin
      if (aw_q == cfg_port_pkg::CTL_ADDR_OFS) instr <= w_q[15:0];
      if (aw_q == cfg_port_pkg::CTL_DATA_OFS) wbyte <= w_q[7:0];
      if (aw_q == cfg_port_pkg::CTL_CMD_OFS) sel_lsb <= {1'b0, w_q[1]};
    end
  end

  // Read channel.
  assign arready = !rvalid;
  assign rresp   = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0; rdata <= 32'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      case (araddr)
        cfg_port_pkg::CTL_ADDR_OFS: rdata <= {16'h0, instr};
        cfg_port_pkg::CTL_DATA_OFS: rdata <= {24'h0, wbyte};
        cfg_port_pkg::CTL_STAT_OFS: rdata <= {23'h0, rbyte, busy};
        default:                    rdata <= 32'h0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Reverses a byte so an LSB-first byte leaves through the MSB end.
  function automatic logic [7:0] flip8(input logic [7:0] b);
    for (int k = 0; k < 8; k++) flip8[k] = b[7 - k];
  endfunction : flip8

  // Serial engine: 24 bits, one instruction and one data byte.
  logic [4:0] nbit;
  logic [2:0] div;
  logic [23:0] sh;
  logic is_rd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0; nbit <= 5'h0; div <= 3'h0; sh <= 24'h0;
      port.sclk <= 1'b0; port.cs1_n <= 1'b1; port.cs2_n <= 1'b1;
      port.sdio_ctl_o <= 1'b0; port.sdio_ctl_oe_n <= 1'b1;
      rbyte <= 8'h00; is_rd <= 1'b0;
    end else if (start) begin
      busy <= 1'b1; nbit <= 5'h1; div <= 3'h0;
      is_rd <= instr[15];
      // The first bit leaves with the select, so the first rise takes it.
      port.sdio_ctl_o <= instr[15];
      port.sdio_ctl_oe_n <= 1'b0;
      sh <= {2'h0, instr[12:0],
             w_q[1] ? flip8(wbyte) : wbyte, 1'b0};
      port.cs1_n <= 1'b0; port.cs2_n <= 1'b0;
    end else if (busy) begin
      div <= div + 3'h1;
      if (div == 3'(cfg_port_pkg::SCLK_HALF - 1)) begin
        div <= 3'h0;
        port.sclk <= !port.sclk;
        if (!port.sclk) begin
          // Rising edge: capture read bits.
          if (is_rd && nbit > 5'd16)
            rbyte <= sel_lsb[0] ? {port.sdio, rbyte[7:1]}
                                : {rbyte[6:0], port.sdio};
        end else if (nbit == 5'd24) begin
          // The fall after the last rise closes the frame; the port then
          // idles so its noise stays away from the sampling.
          busy <= 1'b0; port.cs1_n <= 1'b1; port.cs2_n <= 1'b1;
          port.sdio_ctl_oe_n <= 1'b1;
        end else begin
          // Falling edge: launch next bit.
          port.sdio_ctl_o <= sh[23];
          port.sdio_ctl_oe_n <= is_rd && nbit >= 5'd16;
          sh <= {sh[22:0], 1'b0};
          nbit <= nbit + 5'h1;
        end
      end
    end
  end
endmodule : cfg_port_ctrl

// ### test/cfg_port_asserts.sv
`timescale 1ns/1ps
// Watches the serial link between controller and device.
module cfg_port_asserts (
  input wire logic aclk,          // System clock.
  input wire logic aresetn,       // Synchronous reset, low.
  input wire logic sclk,          // Shift clock.
  input wire logic cs1_n,         // Bank one select.
  input wire logic cs2_n,         // Bank two select.
  input wire logic sdio_ctl_o,    // Controller data out.
  input wire logic sdio_ctl_oe_n, // Controller drives when low.
  input wire logic sdio_dev_o,    // Device data out.
  input wire logic sdio_dev_oe_n, // Device drives when low.
  input wire logic sdio           // Resolved line.
);
  logic       sclk_q;
  logic [5:0] rise_cnt;
  logic       rd_frame;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Previous shift clock sample, for rise detection.
  always_ff @(posedge aclk) begin
    sclk_q <= aresetn ? sclk : 1'b0;
  end

  // Counts shift clock rises inside a frame; saturates so it never wraps.
  always_ff @(posedge aclk) begin
    if (!aresetn || cs1_n) rise_cnt <= 6'h00;
    else if (sclk && !sclk_q && rise_cnt != 6'h3f)
      rise_cnt <= rise_cnt + 6'h01;
  end

  // The first bit of a frame tells a read from a write.
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_frame <= 1'b0;
    else if (!cs1_n && sclk && !sclk_q && rise_cnt == 6'h00) rd_frame <= sdio;
  end

  a_selects_tied: assert property (cs1_n == cs2_n)
    else $error("bank selects differ");
  a_frame_start: assert property ($fell(cs1_n) |-> !sclk)
    else $error("frame opened with shift clock high");
  a_sclk_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("shift clock high phase not four cycles");
  a_frame_length: assert property ($rose(cs1_n) |-> rise_cnt == 6'd24)
    else $error("frame did not hold 24 clock rises");
  // The turn allows the device's synchroniser delay plus half a period.
  a_read_turn: assert property (
    $rose(sclk) && rise_cnt == 6'd15 && rd_frame
    |-> ##[1:8] !sdio_dev_oe_n)
    else $error("device late turning the data line");
  a_write_quiet: assert property (
    !cs1_n && !rd_frame && rise_cnt != 6'd0 |-> sdio_dev_oe_n)
    else $error("device drives during a write frame");
  a_instr_quiet: assert property (
    !cs1_n && rise_cnt < 6'd16 |-> sdio_dev_oe_n)
    else $error("device drives during the instruction");
  a_dev_launch_fall: assert property (
    !sdio_dev_oe_n && !$past(sdio_dev_oe_n) && $changed(sdio_dev_o)
    |-> !sclk)
    else $error("device changed data while clock high");
  a_ctrl_launch_fall: assert property (
    !sdio_ctl_oe_n && !cs1_n && $changed(sdio_ctl_o) |-> !sclk)
    else $error("controller changed data while clock high");
  a_idle_release: assert property (
    (cs1_n && cs2_n)[*4] |-> sdio_dev_oe_n && sdio_ctl_oe_n)
    else $error("data line driven while deselected");

  c_read_turn: cover property ($rose(sclk) && rise_cnt == 6'd15 && rd_frame);
  c_write_end: cover property ($rose(cs1_n) && !rd_frame);
  c_read_end: cover property ($rose(cs1_n) && rd_frame);
endmodule : cfg_port_asserts

// ### test/adc_serial_config_port_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end
module adc_serial_config_port_tb;
  logic        aclk, aresetn, sample_clk_ok, pd_pin, two_lane, powered_down;
  logic [13:0] adc_sample;
  logic [15:0] out_word;
  logic [1:0]  bank_access, bresp, rresp;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          num_errors, n_compared;
  cfg_port_if link();
  cfg_port_device i_cfg_port_device (.aclk(aclk), .aresetn(aresetn),
    .port(link), .sample_clk_ok(sample_clk_ok), .power_down_pin(pd_pin),
    .adc_sample(adc_sample), .out_word(out_word), .two_lane(two_lane),
    .powered_down(powered_down), .bank_access(bank_access));
  cfg_port_ctrl i_cfg_port_ctrl (.aclk(aclk), .aresetn(aresetn), .port(link),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .power_down_pin(pd_pin));
  cfg_port_asserts i_cfg_port_asserts (.aclk(aclk), .aresetn(aresetn),
    .sclk(link.sclk), .cs1_n(link.cs1_n), .cs2_n(link.cs2_n),
    .sdio_ctl_o(link.sdio_ctl_o), .sdio_ctl_oe_n(link.sdio_ctl_oe_n),
    .sdio_dev_o(link.sdio_dev_o), .sdio_dev_oe_n(link.sdio_dev_oe_n),
    .sdio(link.sdio));

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // One register write; address and data are offered together.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int   i;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!wd && wready === 1'b1) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 64) begin
      num_errors++;
      wrap_up();
    end
  endtask : axi_wr

  // One register read; data taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int   i;
    logic ad;
    ad = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (!ad && arready === 1'b1) begin
        arvalid <= 1'b0;
        ad = 1'b1;
      end
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rready <= 1'b0;
    if (i == 64) begin
      num_errors++;
      wrap_up();
    end
  endtask : axi_rd

  // Runs one serial frame and returns the byte read back.
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input logic [7:0] d, input logic lsb,
                      output logic [7:0] rb);
    logic [31:0] s;
    int          i;
    axi_wr(cfg_port_pkg::CTL_ADDR_OFS, {16'h0000, rd, 2'b00, a});
    axi_wr(cfg_port_pkg::CTL_DATA_OFS, {24'h000000, d});
    axi_wr(cfg_port_pkg::CTL_CMD_OFS, {30'h00000000, lsb, 1'b1});
    // The selects reach the device through its two-flop synchroniser.
    repeat (2) @(posedge aclk);
    `CHK(bank_access, 2'b11)
    for (i = 0; i < 200; i++) begin
      axi_rd(cfg_port_pkg::CTL_STAT_OFS, s);
      if (s[0] === 1'b0) break;
    end
    if (i == 200) begin
      num_errors++;
      wrap_up();
    end
    rb = s[8:1];
  endtask : xfer

  // Free-running system clock.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    logic [7:0] rb;
    logic [3:0] modes [3];
    int         i;
    modes = '{4'h6, 4'h5, cfg_port_pkg::TEST_ONE_HIGH};
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    wstrb = 4'hf;
    sample_clk_ok = 1'b1;
    adc_sample = 14'h0155;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(two_lane, 1'b0)
    `CHK(powered_down, 1'b0)
    `CHK(bank_access, 2'b00)
    xfer(1'b1, cfg_port_pkg::CHIP_ID_ADDR, 8'h00, 1'b0, rb);
    `CHK(rb, cfg_port_pkg::CHIP_ID_VALUE)
    xfer(1'b1, cfg_port_pkg::PORT_CFG_ADDR, 8'h00, 1'b0, rb);
    `CHK(rb, cfg_port_pkg::PORT_CFG_RESET)
    xfer(1'b1, cfg_port_pkg::TEST_CTRL_ADDR, 8'h00, 1'b0, rb);
    `CHK(rb, cfg_port_pkg::TEST_CTRL_RESET)
    // Every pattern mode is written and read back; one-high is left on.
    foreach (modes[k]) begin
      xfer(1'b0, cfg_port_pkg::TEST_CTRL_ADDR, {4'h0, modes[k]}, 1'b0, rb);
      xfer(1'b1, cfg_port_pkg::TEST_CTRL_ADDR, 8'h00, 1'b0, rb);
      `CHK(rb, {4'h0, modes[k]})
    end
    for (i = 0; i < 32 && out_word !== cfg_port_pkg::ONE_HIGH_WORD; i++)
      @(posedge aclk);
    `CHK(out_word, cfg_port_pkg::ONE_HIGH_WORD)
    xfer(1'b0, cfg_port_pkg::TEST_CTRL_ADDR, 8'h00, 1'b0, rb);
    repeat (8) @(posedge aclk);
    `CHK(out_word, {14'h0155, 2'h0})
    // A held reset bit pins a generator at its seed; without the sample
    // clock it stays there after the bit is cleared.
    xfer(1'b0, cfg_port_pkg::TEST_CTRL_ADDR, 8'h26, 1'b0, rb);
    repeat (4) @(posedge aclk);
    `CHK(out_word, {cfg_port_pkg::PN9_SEED, 7'h00})
    sample_clk_ok <= 1'b0;
    xfer(1'b0, cfg_port_pkg::TEST_CTRL_ADDR, 8'h06, 1'b0, rb);
    repeat (4) @(posedge aclk);
    `CHK(out_word, {cfg_port_pkg::PN9_SEED, 7'h00})
    sample_clk_ok <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(out_word === {cfg_port_pkg::PN9_SEED, 7'h00}, 1'b0)
    xfer(1'b0, cfg_port_pkg::TEST_CTRL_ADDR, 8'h15, 1'b0, rb);
    repeat (4) @(posedge aclk);
    `CHK(out_word, cfg_port_pkg::PN23_SEED[22:7])
    xfer(1'b0, cfg_port_pkg::TEST_CTRL_ADDR, 8'h0b, 1'b0, rb);
    // The mirrored value reads the same in either bit order.
    xfer(1'b0, cfg_port_pkg::PORT_CFG_ADDR, 8'h5a, 1'b0, rb);
    xfer(1'b1, cfg_port_pkg::CHIP_ID_ADDR, 8'h00, 1'b1, rb);
    `CHK(rb, cfg_port_pkg::CHIP_ID_VALUE)
    xfer(1'b1, cfg_port_pkg::PORT_CFG_ADDR, 8'h00, 1'b1, rb);
    `CHK(rb, 8'h5a)
    xfer(1'b0, cfg_port_pkg::PORT_CFG_ADDR, 8'h7e, 1'b1, rb);
    xfer(1'b1, cfg_port_pkg::PORT_CFG_ADDR, 8'h00, 1'b0, rb);
    `CHK(rb, cfg_port_pkg::PORT_CFG_RESET)
    xfer(1'b1, cfg_port_pkg::TEST_CTRL_ADDR, 8'h00, 1'b0, rb);
    `CHK(rb, cfg_port_pkg::TEST_CTRL_RESET)
    repeat (4) @(posedge aclk);
    `CHK(bank_access, 2'b00)
    wrap_up();
  end
endmodule : adc_serial_config_port_tb
